//--- rtl/clkgen_pkg.sv
// Package for the clock generator control block: offsets, field layout,
// reset values and shared types.
// Assumes a 32-bit Avalon-MM byte address and a single system clock.
package clkgen_pkg;

  // ********************************************************************
  // Register byte addresses
  // ********************************************************************
  localparam logic [31:0] ADDR_CONTROL_STATUS = 32'h01b7_c100;
  localparam logic [31:0] ADDR_MULTIPLIER = 32'h01b7_c110;
  localparam logic [31:0] ADDR_PRESCALE = 32'h01b7_c114;
  localparam logic [31:0] ADDR_CORE = 32'h01b7_c118;
  localparam logic [31:0] ADDR_PERIPH = 32'h01b7_c11c;
  localparam logic [31:0] ADDR_MEMIF = 32'h01b7_c120;
  localparam logic [31:0] ADDR_AUX = 32'h01b7_c124;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int BIT_PATH_SEL = 0;
  localparam int BIT_SLEEP_SEL = 1;
  localparam int BIT_RESET_CTL = 3;
  localparam int BIT_STABLE = 6;
  localparam int BIT_DIV_ENABLE = 15;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic RST_PATH_SEL = 1'b0;
  localparam logic RST_SLEEP_SEL = 1'b0;
  localparam logic RST_RESET_CTL = 1'b1;
  localparam logic RST_DIV_ENABLE = 1'b1;
  localparam logic [4:0] RST_MULTIPLY_CODE = 5'h07;
  localparam logic [4:0] RST_PRESCALE_RATIO = 5'h00;
  localparam logic [4:0] RST_CORE_RATIO = 5'h00;
  localparam logic [4:0] RST_PERIPH_RATIO = 5'h01;
  localparam logic [4:0] RST_MEMIF_RATIO = 5'h01;
  localparam logic [4:0] RST_AUX_RATIO = 5'h07;

  // ********************************************************************
  // Counts of cycles
  // ********************************************************************
  // Input clock settle count; value is a plain default.
  localparam logic [11:0] STABLE_CYCLES = 12'h0400;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic enable;
    logic [4:0] ratio;
  } div_ctl_type;

  typedef struct packed {
    logic path_sel;
    logic sleep_sel;
    logic reset_ctl;
  } pll_ctl_type;

endpackage

//--- rtl/clkgen_regs.sv
// Clock generator control: register file on Avalon-MM and five ratio
// dividers producing one-cycle clock ticks for the system clocks.
// Assumes the analog PLL output arrives asynchronously on PLL_OUT and is
// far slower than CLK, so its rising edges can be counted as ticks.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps

// **********************************************************************
// Ratio divider
// **********************************************************************
module clk_ratio_div
  import clkgen_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Control and ticks.
  input wire logic in_tick,
  input div_ctl_type ctl,
  output logic out_tick
);

  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } div_state_type;

  div_state_type st_r;
  div_state_type st_nxt;

  // Counts input ticks and emits one output tick per ratio plus one.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!ctl.enable)
    begin
      st_nxt.cnt = 5'h00;
    end
    else if (in_tick)
    begin
      // A lowered ratio must not strand the count above it, hence >=.
      if (st_r.cnt >= ctl.ratio)
      begin
        st_nxt.cnt = 5'h00;
        st_nxt.tick = 1'b1;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt + 5'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign out_tick = st_r.tick;

endmodule

// **********************************************************************
// Top level
// **********************************************************************
module clkgen_regs
  import clkgen_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic SRST,
  // Avalon-MM slave.
  input wire logic [31:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Analog PLL macro.
  input wire logic PLL_OUT,
  output logic PLL_RESET,
  output logic PLL_SLEEP,
  output logic [4:0] PLL_MULTIPLY_CODE,
  output logic PLL_REF_TICK,
  // Divided clock ticks.
  output logic CORE_CLOCK_TICK,
  output logic PERIPH_BUS_CLOCK_TICK,
  output logic MEMIF_CLOCK_TICK,
  output logic AUX_CLOCK_OUT_TICK
);

  typedef struct packed {
    pll_ctl_type pll;
    logic [4:0] multiply_code;
    div_ctl_type prescale;
    div_ctl_type core;
    div_ctl_type periph;
    div_ctl_type memif;
    div_ctl_type aux;
    logic [11:0] stable_cnt;
    logic stable;
    logic ack;
    logic [31:0] rdata;
    logic [2:0] pll_sync;
  } top_state_type;

  top_state_type st_r;
  top_state_type st_nxt;
  logic pll_edge;
  logic sys_ref_tick;
  logic wr_take;

  // A write lands only at the edge where waitrequest is seen low.
  assign wr_take = AVS_WRITE & st_r.ack;
  assign pll_edge = st_r.pll_sync[1] & ~st_r.pll_sync[2];

  // Bypass feeds every CLK cycle straight to the post-scalers.
  assign sys_ref_tick = st_r.pll.path_sel ? pll_edge : 1'b1;

  // Merges a write into a divider control, honouring byte enables.
  function automatic div_ctl_type div_write(input div_ctl_type old, input logic [31:0] d,
                                            input logic [3:0] be);
    div_ctl_type res;
    res = old;
    if (be[0])
    begin
      res.ratio = d[4:0];
    end
    if (be[1])
    begin
      res.enable = d[BIT_DIV_ENABLE];
    end
    return res;
  endfunction

  // Builds the read image of a divider control; reserved bits are zero.
  function automatic logic [31:0] div_read(input div_ctl_type c);
    logic [31:0] res;
    res = 32'h0000_0000;
    res[BIT_DIV_ENABLE] = c.enable;
    res[4:0] = c.ratio;
    return res;
  endfunction

  // Bus handshake, register writes, read mux, settle counter, sync.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pll_sync = {st_r.pll_sync[1:0], PLL_OUT};
    st_nxt.ack = (AVS_READ | AVS_WRITE) & ~st_r.ack;
    if (!st_r.stable)
    begin
      if (st_r.stable_cnt == STABLE_CYCLES)
      begin
        st_nxt.stable = 1'b1;
      end
      else
      begin
        st_nxt.stable_cnt = st_r.stable_cnt + 12'h001;
      end
    end
    if (AVS_READ & ~st_r.ack)
    begin
      case (AVS_ADDRESS)
        ADDR_CONTROL_STATUS:
        begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rdata[BIT_STABLE] = st_r.stable;
          st_nxt.rdata[BIT_RESET_CTL] = st_r.pll.reset_ctl;
          st_nxt.rdata[BIT_SLEEP_SEL] = st_r.pll.sleep_sel;
          st_nxt.rdata[BIT_PATH_SEL] = st_r.pll.path_sel;
        end
        ADDR_MULTIPLIER: st_nxt.rdata = {27'h000_0000, st_r.multiply_code};
        ADDR_PRESCALE: st_nxt.rdata = div_read(st_r.prescale);
        ADDR_CORE: st_nxt.rdata = div_read(st_r.core);
        ADDR_PERIPH: st_nxt.rdata = div_read(st_r.periph);
        ADDR_MEMIF: st_nxt.rdata = div_read(st_r.memif);
        ADDR_AUX: st_nxt.rdata = div_read(st_r.aux);
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_take)
    begin
      case (AVS_ADDRESS)
        ADDR_CONTROL_STATUS:
        begin
          // Bit 2 is dropped here, so a stray one written there is harmless.
          if (AVS_BYTEENABLE[0])
          begin
            st_nxt.pll.reset_ctl = AVS_WRITEDATA[BIT_RESET_CTL];
            st_nxt.pll.sleep_sel = AVS_WRITEDATA[BIT_SLEEP_SEL];
            st_nxt.pll.path_sel = AVS_WRITEDATA[BIT_PATH_SEL];
          end
        end
        ADDR_MULTIPLIER:
        begin
          if (AVS_BYTEENABLE[0])
          begin
            st_nxt.multiply_code = AVS_WRITEDATA[4:0];
          end
        end
        ADDR_PRESCALE: st_nxt.prescale = div_write(st_r.prescale, AVS_WRITEDATA, AVS_BYTEENABLE);
        ADDR_CORE: st_nxt.core = div_write(st_r.core, AVS_WRITEDATA, AVS_BYTEENABLE);
        ADDR_PERIPH: st_nxt.periph = div_write(st_r.periph, AVS_WRITEDATA, AVS_BYTEENABLE);
        ADDR_MEMIF: st_nxt.memif = div_write(st_r.memif, AVS_WRITEDATA, AVS_BYTEENABLE);
        ADDR_AUX: st_nxt.aux = div_write(st_r.aux, AVS_WRITEDATA, AVS_BYTEENABLE);
        default: st_nxt.ack = 1'b0;
      endcase
    end
  end

  // State register with documented reset values.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      st_r <= '0;
      st_r.pll.reset_ctl <= RST_RESET_CTL;
      st_r.pll.sleep_sel <= RST_SLEEP_SEL;
      st_r.pll.path_sel <= RST_PATH_SEL;
      st_r.multiply_code <= RST_MULTIPLY_CODE;
      st_r.prescale <= '{RST_DIV_ENABLE, RST_PRESCALE_RATIO};
      st_r.core <= '{RST_DIV_ENABLE, RST_CORE_RATIO};
      st_r.periph <= '{RST_DIV_ENABLE, RST_PERIPH_RATIO};
      st_r.memif <= '{RST_DIV_ENABLE, RST_MEMIF_RATIO};
      st_r.aux <= '{RST_DIV_ENABLE, RST_AUX_RATIO};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Prescaler ahead of the PLL reference input; idle while bypassed.
  clk_ratio_div u_prescale (
    .clk(CLK),
    .srst(SRST),
    .in_tick(st_r.pll.path_sel),
    .ctl(st_r.prescale),
    .out_tick(PLL_REF_TICK)
  );

  // Core clock post-scaler.
  clk_ratio_div u_core (
    .clk(CLK),
    .srst(SRST),
    .in_tick(sys_ref_tick),
    .ctl(st_r.core),
    .out_tick(CORE_CLOCK_TICK)
  );

  // Peripheral bus clock post-scaler.
  clk_ratio_div u_periph (
    .clk(CLK),
    .srst(SRST),
    .in_tick(sys_ref_tick),
    .ctl(st_r.periph),
    .out_tick(PERIPH_BUS_CLOCK_TICK)
  );

  // Memory interface clock post-scaler.
  clk_ratio_div u_memif (
    .clk(CLK),
    .srst(SRST),
    .in_tick(sys_ref_tick),
    .ctl(st_r.memif),
    .out_tick(MEMIF_CLOCK_TICK)
  );

  // Aux divider always runs from the input clock, never the PLL.
  clk_ratio_div u_aux (
    .clk(CLK),
    .srst(SRST),
    .in_tick(1'b1),
    .ctl(st_r.aux),
    .out_tick(AUX_CLOCK_OUT_TICK)
  );

  // Outputs; waitrequest is combinational so the answer takes one wait cycle.
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~st_r.ack;
  assign AVS_READDATA = st_r.rdata;
  assign PLL_RESET = st_r.pll.reset_ctl;
  assign PLL_SLEEP = st_r.pll.sleep_sel;
  assign PLL_MULTIPLY_CODE = st_r.multiply_code;

endmodule

//--- testbench/clkgen_monitor.sv
// Checker for the clock generator control block.
// Assumes it is bound into clkgen_regs and sees only its ports.
`timescale 1ns/100ps
module clkgen_monitor
  import clkgen_pkg::*;
(
  // Clock, reset and bus.
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [31:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic AVS_READ,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Outputs under watch.
  input wire logic PLL_RESET,
  input wire logic PLL_SLEEP,
  input wire logic [4:0] PLL_MULTIPLY_CODE,
  input wire logic AUX_CLOCK_OUT_TICK
);
  // ****
  // Helper logic
  // ****
  logic [11:0] up_r;
  logic [31:0] wd_r;
  logic aux_en_r;
  logic wr_ok;
  logic rd_ok;
  logic ctl;
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
  assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
  assign ctl = AVS_ADDRESS == ADDR_CONTROL_STATUS;
  // Saturating age since reset; the settle bit is judged against it.
  always_ff @(posedge CLK)
  begin
    wd_r <= AVS_WRITEDATA;
    if (SRST)
      up_r <= 12'h000;
    else if (up_r != 12'hfff)
      up_r <= up_r + 12'h001;
    if (SRST)
      aux_en_r <= 1'b1;
    else if (wr_ok && AVS_ADDRESS == ADDR_AUX && AVS_BYTEENABLE[1])
      aux_en_r <= AVS_WRITEDATA[15];
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_ctl_wr;
    wr_ok && ctl && AVS_BYTEENABLE[0];
  endsequence
  property p_rst_ctl;
    s_ctl_wr |=> PLL_RESET == wd_r[3];
  endproperty
  a_rst_ctl: assert property (p_rst_ctl) else $error("reset bit mismatch");
  property p_sleep;
    s_ctl_wr |=> PLL_SLEEP == wd_r[1];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep bit mismatch");
  property p_mult;
    wr_ok && AVS_ADDRESS == ADDR_MULTIPLIER && AVS_BYTEENABLE[0]
      |=> PLL_MULTIPLY_CODE == wd_r[4:0];
  endproperty
  a_mult: assert property (p_mult) else $error("multiply code mismatch");
  property p_rst_val;
    $fell(SRST) |-> PLL_RESET && !PLL_SLEEP && PLL_MULTIPLY_CODE == 5'h07;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset value");
  property p_resv;
    rd_ok |-> AVS_READDATA[31:16] == 16'h0000 && AVS_READDATA[14:7] == 8'h00
      && !AVS_READDATA[5];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_unst;
    rd_ok && ctl && up_r < 12'h03e8 |-> !AVS_READDATA[6];
  endproperty
  a_unst: assert property (p_unst) else $error("settle bit early");
  property p_stab;
    rd_ok && ctl && up_r > 12'h040c |-> AVS_READDATA[6];
  endproperty
  a_stab: assert property (p_stab) else $error("settle bit missing");
  property p_hold;
    !(wr_ok && ctl) |=> $stable(PLL_RESET) && $stable(PLL_SLEEP);
  endproperty
  a_hold: assert property (p_hold) else $error("control moved unwritten");
  property p_aux_off;
    !aux_en_r [*3] |-> !AUX_CLOCK_OUT_TICK;
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux tick while off");
endmodule

bind clkgen_regs clkgen_monitor mon (.CLK, .SRST, .AVS_ADDRESS, .AVS_WRITE, .AVS_READ,
  .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .PLL_RESET,
  .PLL_SLEEP, .PLL_MULTIPLY_CODE, .AUX_CLOCK_OUT_TICK);

//--- testbench/tb.sv
// Self-checking bench for the clock generator control block.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/100ps
module tb
  import clkgen_pkg::*;
;
  // ****
  // Signals and register mirror
  // ****
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] be = '0;
  logic pll_out = 1'b0;
  logic [31:0] rdata;
  logic wait_req;
  wire [4:0] ticks;
  logic [31:0] exp_q[$];
  logic [31:0] mirror [8];
  logic stable_exp = 1'b0;
  logic [31:0] d;
  int ph = 0;
  int num_errors = 0;
  int samples_checked = 0;
  localparam logic [31:0] ADR [8] = '{ADDR_CONTROL_STATUS, ADDR_MULTIPLIER, ADDR_PRESCALE,
    ADDR_CORE, ADDR_PERIPH, ADDR_MEMIF, ADDR_AUX, 32'h01b7_c128};
  localparam logic [31:0] WMASK [8] = '{32'h0000_000b, 32'h0000_001f, 32'h0000_801f,
    32'h0000_801f, 32'h0000_801f, 32'h0000_801f, 32'h0000_801f, 32'h0000_0000};
  localparam logic [31:0] RSTV [8] = '{32'h0000_0008, 32'h0000_0007, 32'h0000_8000,
    32'h0000_8000, 32'h0000_8001, 32'h0000_8001, 32'h0000_8007, 32'h0000_0000};
  clkgen_regs dut (.CLK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .PLL_OUT(pll_out), .PLL_RESET(), .PLL_SLEEP(),
    .PLL_MULTIPLY_CODE(), .PLL_REF_TICK(ticks[0]), .CORE_CLOCK_TICK(ticks[1]),
    .PERIPH_BUS_CLOCK_TICK(ticks[2]), .MEMIF_CLOCK_TICK(ticks[3]),
    .AUX_CLOCK_OUT_TICK(ticks[4]));
  always #2 clk = ~clk;
  // A slow stand-in for the analog loop: ten input cycles a period.
  always @(posedge clk)
  begin
    ph <= (ph == 4) ? 0 : ph + 1;
    if (ph == 4)
      pll_out <= ~pll_out;
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One bus cycle; the mirror follows only enabled lanes of writable fields.
  task automatic bus(logic w, int i, logic [31:0] v, logic [3:0] b);
    logic [31:0] m;
    int n;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & WMASK[i];
    if (w)
      mirror[i] = (mirror[i] & ~m) | (v & m);
    else
      exp_q.push_back(mirror[i] | ((i == 0 && stable_exp) ? 32'h0000_0040 : 32'h0000_0000));
    @(posedge clk);
    addr <= ADR[i];
    rd <= !w;
    wr <= w;
    wdata <= v;
    be <= b;
    // Waitrequest is judged at the rising edge; the request drops only there.
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (wait_req === 1'b0)
        break;
    end
    if (n == 20)
    begin
      num_errors++;
      end_sim();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Cycles between two ticks; a missing tick ends the run.
  task automatic period(int k, int want);
    int n;
    int t;
    t = -1;
    for (n = 0; n < 600; n++)
    begin
      @(negedge clk);
      if (ticks[k] === 1'b1)
      begin
        if (t >= 0)
          break;
        t = n;
      end
    end
    check("tick period", n - t, want);
    if (n == 600)
      end_sim();
  endtask
  task automatic quiet(int k);
    int c;
    c = 0;
    // Skip the edge that lands the write; a tick launched there is still legal.
    @(posedge clk);
    repeat (200) @(negedge clk) c += int'(ticks[k] !== 1'b0);
    check("stopped ticks", c, 0);
  endtask
  // Read data are taken at the rising edge where waitrequest is seen low.
  always @(posedge clk)
    if (rd && wait_req === 1'b0)
      check("readdata", rdata, exp_q.pop_front());
  initial
  begin
    void'($urandom(32'hffa0adb1));
    mirror = RSTV;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++)
      bus(0, i, 0, 0);
    // Random contents; bypass kept and reserved bit 2 written zero.
    // Core and peripheral dividers are left enabled and untouched.
    repeat (3)
      for (int i = 0; i < 8; i++)
        if (i != 3 && i != 4)
        begin
          d = $urandom & ((i == 0) ? 32'hffff_fffa : 32'hffff_ffff);
          bus(1, i, d, 4'($urandom));
          bus(0, i, 0, 0);
        end
    repeat (1100) @(posedge clk);
    stable_exp = 1'b1;
    bus(0, 0, 0, 0);
    foreach (RSTV[j])
      if (j < 3)
      begin
        d = (j == 0) ? 0 : (j == 1) ? 31 : $urandom % 32;
        bus(1, 6, 32'h0000_8000 | d, 4'h3);
        period(4, d + 1);
      end
    bus(1, 6, 0, 4'h3);
    quiet(4);
    bus(1, 5, 32'h0000_8003, 4'h3);
    period(3, 4);
    bus(1, 5, 0, 4'h3);
    quiet(3);
    // Slow the peripheral bus first so it never passes half the core.
    bus(1, 4, 32'h0000_8005, 4'h3);
    bus(1, 3, 32'h0000_8002, 4'h3);
    period(1, 3);
    period(2, 6);
    quiet(0);
    // Prescaler set to a known ratio while still bypassed.
    bus(1, 2, 32'h0000_8009, 4'h3);
    // Loop reset held past 125 ns, then lock time before leaving bypass.
    bus(1, 0, 32'h0000_0008, 4'h1);
    repeat (32) @(posedge clk);
    bus(1, 0, 0, 4'h1);
    repeat (46875) @(posedge clk);
    bus(1, 0, 1, 4'h1);
    period(0, 10);
    period(1, 30);
    period(2, 60);
    bus(1, 6, 32'h0000_8002, 4'h3);
    period(4, 3);
    for (int i = 0; i < 8; i++)
      bus(0, i, 0, 0);
    end_sim();
  end
endmodule
